// File: inc/peim_regs.vh
`ifndef PEIM_REGS_VH
`define PEIM_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_RAW 8'h00
`define OFS_MASK 8'h04
`define OFS_MASKED 8'h08
`define OFS_SET 8'h0C
`define OFS_CLR 8'h10
`define OFS_IDX 8'h14
`define OFS_EN_SET 8'h18
`define OFS_EN_CLR 8'h1C
`define OFS_PRI0 8'h20
`define OFS_PRI1 8'h24
`define OFS_NMI 8'h28
`define OFS_ROUTE 8'h2C
`define OFS_CORE 8'h30
`define OFS_STS 8'h34
`define OFS_STS_MASK 8'h38

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PRI_W 2
`define PRI_TOP 7
`define PRI_LOW_ZERO 6'h00
`define NMI_SW_BIT 0
`define NMI_PEND_BIT 1
`define FAULT_PEND_BIT 2
`define RT_DMA_EN 0
`define RT_CH0_EN 8
`define RT_CH0_SUB 9
`define RT_CH1_EN 16
`define RT_CH1_SUB 17
`define RT_CH1_SPLIT 19
`define RT_CH1_SUBB 20
`define CORE_LVL_LSB 0
`define CORE_ID_LSB 8
`define STS_DMA 0
`define STS_GEN 1
`define STS_NMI 2
`define STS_W 3

// ----------------------------------------------------------------------
// reset values and fixed codes
// ----------------------------------------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_PRI 2'h0
`define PRI_LOWEST 2'h3
`define LVL_NONE 3'h4
`define SRC_PERIPH 0
`define SRC_GRP_FIRST 1
`define SRC_GRP_SECOND 2

`endif

// File: design/prio_resolve.v
`timescale 1ns/10ps
`include "peim_regs.vh"
// ----------------------------------------------------------------------
// picks the pending entry with the smallest priority code
// ----------------------------------------------------------------------
module prio_resolve #(
   parameter N = 8,
   parameter IW = 3
) (
   input wire [N-1:0] pend,
   input wire [2*N-1:0] pri,
   output reg found,
   output reg [IW-1:0] idx,
   output reg [1:0] best_pri
);
   integer i; // entry walker

   // strict less-than keeps the lower index on equal codes
   always @* begin
      found = 1'b0;
      idx = {IW{1'b0}};
      best_pri = `PRI_LOWEST;
      for (i = 0; i < N; i = i + 1) begin
         if (pend[i] && (!found || pri[2*i +: 2] < best_pri)) begin
            found = 1'b1;
            idx = i[IW-1:0];
            best_pri = pri[2*i +: 2];
         end
      end
   end
endmodule // prio_resolve

// File: design/peripheral_event_interrupt_manager.v
// Summary of operation
// - four priority codes per source: 0,64,128,192
// - smaller priority code wins competition
// - preempt only with strictly smaller code
// - equal codes resolved by lower source number
// - reset, NMI, fault rank above all sources
// - NMI from software bit or error input
// - per-source priority field written by software
// - enable-set and enable-clear registers per source
// - six standard event registers per peripheral
// - mask gates each condition into the event
// - unmasked pending shows raw, masked, makes event
// - index read returns and clears top condition
// - event goes to core, DMA or peripheral
// - fixed core route, DMA route, generic routes
// - generic channels deliver 1:1 or 1:2; here only channel 1 can split, channel 0 is 1:1 only
// - power unit handshake before triggered action
// - grouping merges lines; pins in second group
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
`include "peim_regs.vh"

module peripheral_event_interrupt_manager #(
   parameter NCOND = 8, // peripheral conditions
   parameter NSRC = 8, // controller sources, multiple of 4
   parameter IW = 3, // source index width
   parameter NGPIO = 4, // pin interrupt lines
   parameter NFIRST = 4, // extra lines of the first group
   parameter NSUB = 4 // generic route subscribers
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_q,
   output reg pready_q,
   output reg pslverr_q,
   input wire [NCOND-1:0] cond_in,
   input wire [NSRC-1:0] ext_irq_in,
   input wire [NFIRST-1:0] grp_first_in,
   input wire [NGPIO-1:0] gpio_irq_pin,
   input wire system_control_unit_err_in,
   input wire hard_fault_in,
   input wire core_ack_in,
   input wire core_eoi_in,
   output reg irq_req_q,
   output reg [IW-1:0] irq_id_q,
   output reg nmi_req_q,
   output reg fault_req_q,
   output reg pwr_req_q,
   input wire pwr_ack_in,
   output reg dma_trig_q,
   output reg [NSUB-1:0] sub_trig_q,
   output reg irq_q
);
   // ----------------
   // declarations
   // ----------------
   localparam S_IDLE = 3'b001; // waiting for an event edge
   localparam S_REQ = 3'b010; // asking power unit for domains
   localparam S_FIRE = 3'b100; // delivering the triggers

   reg [NCOND-1:0] raw_event_status_q; // raw condition flags
   reg [NCOND-1:0] event_mask_q; // condition gates
   wire [NCOND-1:0] masked_event_status; // raw and mask
   reg [NSRC-1:0] src_en_q; // per-source enables
   reg [2*NSRC-1:0] pri_q; // two-bit priority code per source
   reg [3:0] active_q; // one bit per level in service
   reg nmi_pend_q; // sticky NMI request
   reg fault_pend_q; // sticky hard fault request
   reg [31:0] route_q; // route configuration
   reg [`STS_W-1:0] sts_q; // sticky block events
   reg [`STS_W-1:0] sts_mask_q; // block interrupt gates
   reg [2:0] state_q; // route sequencer
   reg evt_prev_q; // event level one cycle ago
   reg evt_wait_q; // edge seen while sequencer busy
   reg [NGPIO-1:0] gpio_s1_q; // first sync stage
   reg [NGPIO-1:0] gpio_s2_q; // second sync stage
   reg [NSUB-1:0] sub_hit; // subscribers hit by a fire
   reg [31:0] rd_d; // read mux
   reg err_d; // unmapped address
   reg [2:0] cur_lvl; // level in service, none = 4
   reg nmi_seen_q; // NMI request one cycle ago
   integer k, kl, ks, km; // one loop index per process

   wire wr_acc = psel & penable & pready_q & pwrite; // write commits
   wire rd_acc = psel & penable & pready_q & ~pwrite; // read commits
   wire setup = psel & ~penable; // setup phase
   wire evt = |masked_event_status; // outgoing peripheral event
   wire evt_edge = evt & ~evt_prev_q; // new event
   wire [NSRC-1:0] src_line; // controller inputs
   wire [NSRC-1:0] src_pend; // enabled inputs
   wire best_found; // some source pending
   wire [IW-1:0] best_idx; // winning source
   wire [1:0] best_pri; // its priority code
   wire idx_found; // some condition pending
   wire [IW-1:0] idx_sel; // lowest pending condition

   // ----------------
   // peripheral event register set
   // ----------------
   assign masked_event_status = raw_event_status_q & event_mask_q;

   // lowest condition number ranks first for the index read
   prio_resolve #(.N(NCOND), .IW(IW)) u_idx (
      .pend(masked_event_status),
      .pri({2*NCOND{1'b0}}),
      .found(idx_found),
      .idx(idx_sel),
      .best_pri()
   );

   // raw flags: hardware set beats any clear in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_event_status_q <= {NCOND{1'b0}};
      end else begin
         for (k = 0; k < NCOND; k = k + 1) begin
            if (cond_in[k]) begin
               raw_event_status_q[k] <= 1'b1;
            end else if (wr_acc && paddr == `OFS_SET && pwdata[k]) begin
               raw_event_status_q[k] <= 1'b1;
            end else if (wr_acc && paddr == `OFS_CLR && pwdata[k]) begin
               raw_event_status_q[k] <= 1'b0;
            end else if (rd_acc && paddr == `OFS_IDX && idx_found &&
                         idx_sel == k[IW-1:0]) begin
               raw_event_status_q[k] <= 1'b0;
            end
         end
      end
   end

   // mask register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_mask_q <= {NCOND{1'b0}};
      end else if (wr_acc && paddr == `OFS_MASK) begin
         event_mask_q <= pwdata[NCOND-1:0];
      end
   end

   // ----------------
   // interrupt grouping
   // ----------------
   // pin lines are asynchronous, two stages before use
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_s1_q <= {NGPIO{1'b0}};
         gpio_s2_q <= {NGPIO{1'b0}};
      end else begin
         gpio_s1_q <= gpio_irq_pin;
         gpio_s2_q <= gpio_s1_q;
      end
   end

   // fixed core route, both groups, then plain lines
   assign src_line = {ext_irq_in[NSRC-1:3],
                      |gpio_s2_q,
                      |grp_first_in,
                      evt};
   assign src_pend = src_line & src_en_q;

   // ----------------
   // source enables and priorities
   // ----------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_en_q <= {NSRC{1'b0}};
      end else if (wr_acc && paddr == `OFS_EN_SET) begin
         src_en_q <= src_en_q | pwdata[NSRC-1:0];
      end else if (wr_acc && paddr == `OFS_EN_CLR) begin
         src_en_q <= src_en_q & ~pwdata[NSRC-1:0];
      end
   end

   // one byte per source, only the top two bits are stored
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : g_pri
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pri_q[2*g +: 2] <= `RST_PRI;
            end else if (wr_acc && paddr == `OFS_PRI0 + 4*(g/4)) begin
               pri_q[2*g +: 2] <= pwdata[8*(g%4)+`PRI_TOP -: `PRI_W];
            end
         end
      end
   endgenerate

   // ----------------
   // arbitration and preemption
   // ----------------
   prio_resolve #(.N(NSRC), .IW(IW)) u_arb (
      .pend(src_pend),
      .pri(pri_q),
      .found(best_found),
      .idx(best_idx),
      .best_pri(best_pri)
   );

   // level currently in service: lowest active level
   always @* begin
      cur_lvl = `LVL_NONE;
      for (kl = 3; kl >= 0; kl = kl - 1) begin
         if (active_q[kl]) begin
            cur_lvl = kl[2:0];
         end
      end
   end

   // exception pending flags, set beats the acknowledge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend_q <= 1'b0;
         fault_pend_q <= 1'b0;
      end else begin
         if (system_control_unit_err_in ||
             (wr_acc && paddr == `OFS_NMI && pwdata[`NMI_SW_BIT])) begin
            nmi_pend_q <= 1'b1;
         end else if (core_ack_in && nmi_req_q) begin
            nmi_pend_q <= 1'b0;
         end
         if (hard_fault_in) begin
            fault_pend_q <= 1'b1;
         end else if (core_ack_in && fault_req_q && !nmi_req_q) begin
            fault_pend_q <= 1'b0;
         end
      end
   end

   // requests to the core; NMI over fault over any source
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_req_q <= 1'b0;
         fault_req_q <= 1'b0;
         irq_req_q <= 1'b0;
         irq_id_q <= {IW{1'b0}};
      end else begin
         nmi_req_q <= nmi_pend_q;
         fault_req_q <= fault_pend_q & ~nmi_pend_q;
         irq_req_q <= best_found & ~nmi_pend_q & ~fault_pend_q &
                      ({1'b0, best_pri} < cur_lvl) &
                      ~(core_ack_in & irq_req_q);
         irq_id_q <= best_idx;
      end
   end

   // active levels: acknowledge pushes, end of service pops lowest
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= 4'h0;
      end else if (core_ack_in && irq_req_q && !nmi_req_q && !fault_req_q) begin
         active_q[pri_q[2*irq_id_q +: 2]] <= 1'b1;
      end else if (core_eoi_in && cur_lvl != `LVL_NONE) begin
         active_q[cur_lvl[1:0]] <= 1'b0;
      end
   end

   // ----------------
   // DMA and generic routes with power handshake
   // ----------------
   // subscribers reached by both channels
   always @* begin
      sub_hit = {NSUB{1'b0}};
      if (route_q[`RT_CH0_EN]) begin
         sub_hit[route_q[`RT_CH0_SUB +: 2]] = 1'b1;
      end
      if (route_q[`RT_CH1_EN]) begin
         sub_hit[route_q[`RT_CH1_SUB +: 2]] = 1'b1;
         if (route_q[`RT_CH1_SPLIT]) begin
            sub_hit[route_q[`RT_CH1_SUBB +: 2]] = 1'b1;
         end
      end
   end

   // sequencer: request domains, wait grant, then fire once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         evt_prev_q <= 1'b0;
         evt_wait_q <= 1'b0;
         pwr_req_q <= 1'b0;
         dma_trig_q <= 1'b0;
         sub_trig_q <= {NSUB{1'b0}};
      end else begin
         evt_prev_q <= evt;
         dma_trig_q <= 1'b0;
         sub_trig_q <= {NSUB{1'b0}};
         case (state_q)
            S_IDLE: begin
               if (evt_edge || evt_wait_q) begin
                  evt_wait_q <= 1'b0;
                  if (route_q[`RT_DMA_EN] || |sub_hit) begin
                     pwr_req_q <= 1'b1;
                     state_q <= S_REQ;
                  end
               end
            end
            S_REQ: begin
               if (evt_edge) begin
                  evt_wait_q <= 1'b1;
               end
               if (pwr_ack_in) begin
                  state_q <= S_FIRE;
               end
            end
            S_FIRE: begin
               if (evt_edge) begin
                  evt_wait_q <= 1'b1;
               end
               dma_trig_q <= route_q[`RT_DMA_EN];
               sub_trig_q <= sub_hit;
               pwr_req_q <= 1'b0;
               state_q <= S_IDLE;
            end
            default: begin
               pwr_req_q <= 1'b0;
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // route configuration
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_q <= `RST_WORD;
      end else if (wr_acc && paddr == `OFS_ROUTE) begin
         route_q <= pwdata;
      end
   end

   // ----------------
   // block interrupt: sticky status, write one to clear
   // ----------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= {`STS_W{1'b0}};
         sts_mask_q <= {`STS_W{1'b0}};
         irq_q <= 1'b0;
         nmi_seen_q <= 1'b0;
      end else begin
         nmi_seen_q <= nmi_req_q; // nmi flag only on a fresh request
         for (ks = 0; ks < `STS_W; ks = ks + 1) begin
            if ((ks == `STS_DMA && dma_trig_q) ||
                (ks == `STS_GEN && |sub_trig_q) ||
                (ks == `STS_NMI && nmi_req_q && !nmi_seen_q)) begin
               sts_q[ks] <= 1'b1; // set wins over clear
            end else if (wr_acc && paddr == `OFS_STS && pwdata[ks]) begin
               sts_q[ks] <= 1'b0;
            end
         end
         if (wr_acc && paddr == `OFS_STS_MASK) begin
            sts_mask_q <= pwdata[`STS_W-1:0];
         end
         irq_q <= |(sts_q & sts_mask_q);
      end
   end

   // ----------------
   // APB slave: zero wait states, read data latched at setup
   // ----------------
   always @* begin
      rd_d = `RST_WORD;
      err_d = 1'b0;
      case (paddr)
         `OFS_RAW: rd_d[NCOND-1:0] = raw_event_status_q;
         `OFS_MASK: rd_d[NCOND-1:0] = event_mask_q;
         `OFS_MASKED: rd_d[NCOND-1:0] = masked_event_status;
         `OFS_SET: rd_d = `RST_WORD;
         `OFS_CLR: rd_d = `RST_WORD;
         `OFS_IDX: begin
            if (idx_found) begin
               rd_d[IW:0] = {1'b0, idx_sel} + 1'b1;
            end
         end
         `OFS_EN_SET: rd_d[NSRC-1:0] = src_en_q;
         `OFS_EN_CLR: rd_d[NSRC-1:0] = src_en_q;
         `OFS_PRI0, `OFS_PRI1: begin
            for (km = 0; km < NSRC; km = km + 1) begin
               if (paddr == `OFS_PRI0 + 4*(km/4)) begin
                  rd_d[8*(km%4) +: 8] = {pri_q[2*km +: 2], `PRI_LOW_ZERO};
               end
            end
         end
         `OFS_NMI: begin
            rd_d[`NMI_PEND_BIT] = nmi_pend_q;
            rd_d[`FAULT_PEND_BIT] = fault_pend_q;
         end
         `OFS_ROUTE: rd_d = route_q;
         `OFS_CORE: begin
            rd_d[`CORE_LVL_LSB +: 4] = active_q;
            rd_d[`CORE_ID_LSB +: IW] = irq_id_q;
         end
         `OFS_STS: rd_d[`STS_W-1:0] = sts_q;
         `OFS_STS_MASK: rd_d[`STS_W-1:0] = sts_mask_q;
         default: err_d = 1'b1;
      endcase
   end

   // ready one cycle after setup; data and error stand with it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `RST_WORD;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & err_d; // error stands with ready only
         if (setup) begin
            prdata_q <= pwrite ? `RST_WORD : rd_d;
         end
      end
   end
endmodule // peripheral_event_interrupt_manager

// File: test/peim_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// port checker for the event and interrupt manager
// ----------------------------------------------------------------------
module peim_checker #(
   parameter NSUB = 4 // generic route subscribers
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [31:0] prdata_q,
   input wire pready_q,
   input wire pslverr_q,
   input wire system_control_unit_err_in,
   input wire hard_fault_in,
   input wire core_ack_in,
   input wire irq_req_q,
   input wire nmi_req_q,
   input wire fault_req_q,
   input wire pwr_req_q,
   input wire pwr_ack_in,
   input wire dma_trig_q,
   input wire [NSUB-1:0] sub_trig_q
);
   // one domain: shared clock and reset
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ready_after_setup: assert property (psel && !penable |=> pready_q)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_q |=> !pready_q)
      else $error("ready held too long");
   a_err_reads_zero: assert property (pslverr_q |-> pready_q && prdata_q == 32'h0000_0000)
      else $error("error without ready or with data");
   a_irq_ack_drop: assert property (irq_req_q && core_ack_in && !nmi_req_q
      && !fault_req_q |=> !irq_req_q)
      else $error("irq request kept after ack");
   a_nmi_from_err: assert property ($rose(system_control_unit_err_in) && !nmi_req_q |-> ##[1:3] nmi_req_q)
      else $error("error input gave no nmi");
   a_fault_raise: assert property ($rose(hard_fault_in) && !fault_req_q && !nmi_req_q
      && !system_control_unit_err_in |-> ##[1:3] fault_req_q)
      else $error("fault input gave no request");
   a_trig_after_grant: assert property (dma_trig_q || (|sub_trig_q)
      |-> $past(pwr_ack_in, 2) && $past(pwr_req_q))
      else $error("trigger without power grant");
   a_pwr_req_held: assert property (pwr_req_q |=> pwr_req_q || dma_trig_q || (|sub_trig_q))
      else $error("power request dropped early");
   a_trig_single: assert property (dma_trig_q |=> !dma_trig_q)
      else $error("dma trigger longer than a pulse");
endmodule // peim_checker

bind peripheral_event_interrupt_manager peim_checker #(.NSUB(NSUB)) u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .prdata_q(prdata_q),
   .pready_q(pready_q),
   .pslverr_q(pslverr_q),
   .system_control_unit_err_in(system_control_unit_err_in),
   .hard_fault_in(hard_fault_in),
   .core_ack_in(core_ack_in),
   .irq_req_q(irq_req_q),
   .nmi_req_q(nmi_req_q),
   .fault_req_q(fault_req_q),
   .pwr_req_q(pwr_req_q),
   .pwr_ack_in(pwr_ack_in),
   .dma_trig_q(dma_trig_q),
   .sub_trig_q(sub_trig_q)
);

// File: test/pwr_unit_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// power and clock unit: grants after a set delay
// ----------------------------------------------------------------------
module pwr_unit_model (
   input wire pclk,
   input wire presetn,
   input wire pwr_req_q,
   input wire [3:0] grant_dly,
   output reg pwr_ack_in
);
   reg [3:0] cnt_q; // cycles since request rose, stops counting at grant_dly

   // grant once the delay ran out, drop with the request
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         pwr_ack_in <= 1'b0;
      end else if (!pwr_req_q) begin // released: no grant
         cnt_q <= 4'h0;
         pwr_ack_in <= 1'b0;
      end else if (cnt_q >= grant_dly) begin
         pwr_ack_in <= 1'b1;
      end else begin // still ramping the domain
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule // pwr_unit_model

// File: test/peripheral_event_interrupt_manager_tb_top.sv
`timescale 1ns/10ps
`include "peim_regs.vh"
module peripheral_event_interrupt_manager_tb_top;
   localparam [31:0] ONE = 32'h0000_0001;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [7:0] paddr = 0, cond_in = 0, ext_irq_in = 0;
   reg [31:0] pwdata = 0, rdat;
   reg [3:0] grp_first_in = 0, gpio_irq_pin = 0, grant_dly = 0;
   reg system_control_unit_err_in = 0, hard_fault_in = 0, core_ack_in = 0, core_eoi_in = 0, rerr;
   wire [31:0] prdata_q;
   wire [2:0] irq_id_q;
   wire [3:0] sub_trig_q;
   wire pready_q, pslverr_q, irq_req_q, nmi_req_q, fault_req_q, pwr_req_q, pwr_ack_in;
   wire dma_trig_q, irq_q;
   integer n_mismatch = 0, num_checks = 0, i;

   always #25 pclk = ~pclk;

   peripheral_event_interrupt_manager u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .cond_in(cond_in),
      .ext_irq_in(ext_irq_in), .grp_first_in(grp_first_in), .gpio_irq_pin(gpio_irq_pin),
      .system_control_unit_err_in(system_control_unit_err_in), .hard_fault_in(hard_fault_in),
      .core_ack_in(core_ack_in), .core_eoi_in(core_eoi_in), .irq_req_q(irq_req_q),
      .irq_id_q(irq_id_q), .nmi_req_q(nmi_req_q), .fault_req_q(fault_req_q),
      .pwr_req_q(pwr_req_q), .pwr_ack_in(pwr_ack_in), .dma_trig_q(dma_trig_q),
      .sub_trig_q(sub_trig_q), .irq_q(irq_q));
   pwr_unit_model u_pwr (.pclk(pclk), .presetn(presetn), .pwr_req_q(pwr_req_q),
      .grant_dly(grant_dly), .pwr_ack_in(pwr_ack_in));

   // ----------------
   // shared helpers
   // ----------------
   task final_report;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task bail;
      begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %0t wait limit", $time);
         final_report();
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      begin
         num_checks = num_checks + 1;
         if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
         end
      end
   endtask
   // apb transfer: setup, then access until ready sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer k;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         do begin
            @(posedge pclk);
            k = k + 1;
            if (k > 20) bail();
         end while (pready_q !== 1'b1);
         rdat = prdata_q;
         rerr = pslverr_q;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, `RST_WORD);
   endtask
   // one-cycle pulse on a core line: 0 ack, 1 end of service
   task core(input integer k);
      begin
         @(posedge pclk);
         if (k == 0) core_ack_in <= 1'b1;
         else core_eoi_in <= 1'b1;
         @(posedge pclk);
         core_ack_in <= 1'b0;
         core_eoi_in <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask
   task pulse_cond(input logic [7:0] v);
      begin
         @(posedge pclk);
         cond_in <= v;
         @(posedge pclk);
         cond_in <= 8'h00;
      end
   endtask
   // wait for a request (k=0) or a trigger pulse (k=1), bounded
   task wait_on(input integer k);
      integer j;
      begin
         j = 0;
         repeat (2) @(posedge pclk);
         while ((k == 0 ? irq_req_q : (dma_trig_q | (|sub_trig_q))) !== 1'b1) begin
            @(posedge pclk);
            j = j + 1;
            if (j > 40) bail();
         end
      end
   endtask

   // ----------------
   // scenarios
   // ----------------
   task t_regs;
      begin
         rd(`OFS_MASK);
         chk(rdat, `RST_WORD);
         rd(8'hFC);
         chk({31'h0, rerr}, ONE);
      end
   endtask
   task t_events;
      begin
         wr(`OFS_MASK, 32'h0000_000F);
         pulse_cond(8'h21);
         rd(`OFS_RAW);
         chk(rdat, 32'h0000_0021);
         wr(`OFS_MASKED, 32'h0000_00FF);
         rd(`OFS_MASKED);
         chk(rdat, ONE);
         wr(`OFS_SET, 32'h0000_0004);
         wr(`OFS_CLR, 32'h0000_0020);
         rd(`OFS_RAW);
         chk(rdat, 32'h0000_0005);
         rd(`OFS_IDX);
         chk(rdat, ONE);
         rd(`OFS_IDX);
         chk(rdat, 32'h0000_0003);
         rd(`OFS_RAW);
         chk(rdat, `RST_WORD);
         wr(`OFS_MASK, `RST_WORD);
      end
   endtask
   task t_prio;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            wr(`OFS_PRI0, {4{i[1:0], 6'h00}});
            rd(`OFS_PRI0);
            chk(rdat, {4{i[1:0], 6'h00}});
         end
         wr(`OFS_PRI0, 32'hC000_0000);
         wr(`OFS_PRI1, 32'h0000_0040);
         wr(`OFS_EN_SET, 32'h0000_0018);
         ext_irq_in <= 8'h18;
         wait_on(0);
         chk(irq_id_q, 32'h0000_0004);
         wr(`OFS_PRI0, 32'h4000_0000);
         wait_on(0);
         chk(irq_id_q, 32'h0000_0003);
         core(0);
         chk({31'h0, irq_req_q}, `RST_WORD);
         wr(`OFS_PRI1, `RST_WORD);
         wait_on(0);
         chk(irq_id_q, 32'h0000_0004);
         core(0);
         core(1);
         core(1);
         wr(`OFS_EN_CLR, 32'h0000_0018);
         rd(`OFS_EN_SET);
         chk(rdat, `RST_WORD);
         ext_irq_in <= 8'h00;
      end
   endtask
   task t_groups;
      begin
         wr(`OFS_EN_SET, 32'h0000_0006);
         gpio_irq_pin <= 4'h2;
         wait_on(0);
         chk(irq_id_q, 32'h0000_0002);
         grp_first_in <= 4'h1;
         wait_on(0);
         chk(irq_id_q, ONE);
         gpio_irq_pin <= 4'h0;
         grp_first_in <= 4'h0;
         wr(`OFS_EN_CLR, 32'h0000_0006);
      end
   endtask
   task t_nmi;
      begin
         @(posedge pclk);
         hard_fault_in <= 1'b1;
         @(posedge pclk);
         hard_fault_in <= 1'b0;
         system_control_unit_err_in <= 1'b1;
         @(posedge pclk);
         system_control_unit_err_in <= 1'b0;
         repeat (3) @(posedge pclk);
         chk({nmi_req_q, fault_req_q}, 32'h0000_0002);
         core(0);
         chk({nmi_req_q, fault_req_q}, ONE);
         core(0);
         chk({31'h0, fault_req_q}, `RST_WORD);
         core(1);
         core(1);
         wr(`OFS_NMI, ONE);
         repeat (3) @(posedge pclk);
         chk({31'h0, nmi_req_q}, ONE);
         core(0);
         core(1);
         wr(`OFS_STS, 32'h0000_0007);
      end
   endtask
   task t_route;
      begin
         grant_dly <= 4'h3;
         wr(`OFS_ROUTE, 32'h003B_0001);
         wr(`OFS_STS_MASK, 32'h0000_0003);
         wr(`OFS_MASK, ONE);
         pulse_cond(8'h01);
         wait_on(1);
         chk({dma_trig_q, sub_trig_q}, 32'h0000_001A);
         rd(`OFS_STS);
         chk(rdat, 32'h0000_0003);
         chk({31'h0, irq_q}, ONE);
         wr(`OFS_STS_MASK, `RST_WORD);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq_q}, `RST_WORD);
         wr(`OFS_STS, 32'h0000_0003);
         rd(`OFS_STS);
         chk(rdat, `RST_WORD);
         grant_dly <= 4'h0;
         wr(`OFS_CLR, ONE);
         wr(`OFS_ROUTE, 32'h0000_0500);
         pulse_cond(8'h01);
         wait_on(1);
         chk({dma_trig_q, sub_trig_q}, 32'h0000_0004);
      end
   endtask

   // ----------------
   // main sequence
   // ----------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_events();
      t_prio();
      t_groups();
      t_nmi();
      t_route();
      final_report();
   end
endmodule // peripheral_event_interrupt_manager_tb_top
